/* design/smlb_half_timer.sv */
// Half-period ticker for the serial clock
`timescale 1ns/10ps
`default_nettype none
module smlb_half_timer (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_run,
	output logic o_tick
);

	logic [smlb_pkg::HALF_CNT_W-1:0] count;
	localparam logic [smlb_pkg::HALF_CNT_W-1:0] LAST =
		smlb_pkg::HALF_CNT_W'(smlb_pkg::HALF_CYCLES - 1);

	// Counter restarts whenever the engine is idle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= '0;
		end else if (!i_run || count == LAST) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	assign o_tick = i_run && (count == LAST);

endmodule
`default_nettype wire

/* design/smlb_master.sv */
// Register-driven serial master with internal loopback
`timescale 1ns/10ps
`default_nettype none
module smlb_master (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_reg_wr_en,
	input wire logic i_reg_rd_en,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rd_valid,
	input wire logic i_miso,
	output smlb_pkg::smlb_pins_t o_pins,
	output logic o_pins_enable,
	output logic o_busy
);

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_FINISH
	} smlb_state_t;

	// Software-visible registers
	logic [7:0] pin_config_one;
	smlb_pkg::smlb_cfg_t serial_master_config;
	logic [7:0] transmit_byte_low;
	logic [7:0] transmit_byte_mid;
	logic [7:0] transmit_byte_high;
	logic [7:0] transfer_execute;
	logic [7:0] comm_diagnostic_control;
	logic [23:0] rx_data;
	logic done_flag;

	// Engine state
	smlb_state_t state;
	logic [23:0] shift_tx;
	logic [5:0] edge_cnt;
	logic [5:0] edge_last;
	logic [4:0] bits_used;
	logic cpha_run;
	logic sclk_int;
	logic mosi_int;
	logic tick;
	logic miso_sync;
	logic data_in;
	logic loopback;
	logic loopback_d;
	logic master_en;
	logic ss_ctrl;
	logic leading;
	logic sample_now;
	logic start;
	logic finish;
	logic wr_exe;
	logic [23:0] tx_word;
	logic [23:0] tx_aligned;
	smlb_pkg::smlb_pins_t pins;

	assign master_en = pin_config_one[smlb_pkg::MASTER_EN_BIT];
	assign loopback = comm_diagnostic_control[smlb_pkg::LOOPBACK_BIT];
	assign ss_ctrl = transfer_execute[smlb_pkg::SS_CTRL_BIT];
	assign wr_exe = i_reg_wr_en && (i_reg_addr == smlb_pkg::ADDR_TRANSFER_EXECUTE);
	assign tx_word = {transmit_byte_high, transmit_byte_mid, transmit_byte_low};

	// Length field clamped into the legal range
	always_comb begin
		if (serial_master_config.bit_count < smlb_pkg::BITS_MIN) begin
			bits_used = smlb_pkg::BITS_MIN;
		end else if (serial_master_config.bit_count > smlb_pkg::BITS_MAX) begin
			bits_used = smlb_pkg::BITS_MAX;
		end else begin
			bits_used = serial_master_config.bit_count;
		end
	end

	// Data left-aligned so the first bit out is the top bit
	assign tx_aligned = tx_word << (6'(smlb_pkg::DATA_WIDTH) - {1'b0, bits_used});

	// Go only while idle, and only with pins or loopback available
	assign start = wr_exe && i_reg_wdata[smlb_pkg::GO_BIT] && (state == ST_IDLE)
		&& (master_en || loopback);
	assign finish = (state == ST_FINISH) && tick;

	// Input path: external pin through synchroniser
	smlb_sync u_miso_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_async(i_miso),
		.o_sync(miso_sync)
	);

	// Loopback replaces the external input with the driven bit
	assign data_in = loopback ? mosi_int : (miso_sync && master_en);

	// Half-period timing of the generated clock
	smlb_half_timer u_half_timer (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_run(state != ST_IDLE),
		.o_tick(tick)
	);

	// Edge role: leading edges are even, sampling edge set by phase
	assign leading = ~edge_cnt[0];
	assign sample_now = leading ^ cpha_run;

	// Configuration and data registers written by the host
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_config_one <= smlb_pkg::RST_PIN_CONFIG_ONE;
			serial_master_config <= smlb_pkg::RST_SERIAL_MASTER_CONFIG[6:0];
			transmit_byte_low <= smlb_pkg::RST_TRANSMIT_BYTE;
			transmit_byte_mid <= smlb_pkg::RST_TRANSMIT_BYTE;
			transmit_byte_high <= smlb_pkg::RST_TRANSMIT_BYTE;
			comm_diagnostic_control <= smlb_pkg::RST_COMM_DIAGNOSTIC_CONTROL;
		end else if (i_reg_wr_en) begin
			case (i_reg_addr)
				smlb_pkg::ADDR_PIN_CONFIG_ONE: begin
					pin_config_one <= i_reg_wdata;
				end
				smlb_pkg::ADDR_SERIAL_MASTER_CONFIG: begin
					serial_master_config <= i_reg_wdata[6:0];
				end
				smlb_pkg::ADDR_TRANSMIT_BYTE_LOW: begin
					transmit_byte_low <= i_reg_wdata;
				end
				smlb_pkg::ADDR_TRANSMIT_BYTE_MID: begin
					transmit_byte_mid <= i_reg_wdata;
				end
				smlb_pkg::ADDR_TRANSMIT_BYTE_HIGH: begin
					transmit_byte_high <= i_reg_wdata;
				end
				smlb_pkg::ADDR_COMM_DIAGNOSTIC_CONTROL: begin
					comm_diagnostic_control <= i_reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Execute register: select control kept, go bit self-clears
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			transfer_execute <= smlb_pkg::RST_TRANSFER_EXECUTE;
		end else if (wr_exe && state == ST_IDLE) begin
			transfer_execute <= {i_reg_wdata[7:1], 1'b0};
		end
	end

	// Completion flag: set at end of transfer, cleared by an execute write
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_flag <= 1'b0;
		end else if (finish) begin
			done_flag <= 1'b1;
		end else if (wr_exe) begin
			done_flag <= 1'b0;
		end
	end

	// Transfer sequencer
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			edge_cnt <= '0;
			edge_last <= '0;
			cpha_run <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start) begin
						state <= ST_SHIFT;
						edge_cnt <= '0;
						edge_last <= {bits_used, 1'b0} - 6'h01;
						cpha_run <= serial_master_config.cpha;
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						edge_cnt <= edge_cnt + 6'h01;
						if (edge_cnt == edge_last) begin
							state <= ST_FINISH;
						end
					end
				end
				ST_FINISH: begin
					if (tick) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Internal serial clock, idling at the polarity level
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sclk_int <= 1'b0;
		end else if (state == ST_SHIFT && tick) begin
			sclk_int <= ~sclk_int;
		end else if (state == ST_IDLE) begin
			sclk_int <= serial_master_config.cpol;
		end
	end

	// Transmit shifter, top bit first
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shift_tx <= '0;
			mosi_int <= 1'b0;
		end else if (start) begin
			mosi_int <= tx_aligned[23];
			if (!serial_master_config.cpha) begin
				shift_tx <= {tx_aligned[22:0], 1'b0};
			end else begin
				shift_tx <= tx_aligned;
			end
		end else if (state == ST_SHIFT && tick && !sample_now) begin
			mosi_int <= shift_tx[23];
			shift_tx <= {shift_tx[22:0], 1'b0};
		end
	end

	// Receive shifter, result ends in the low bits
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_data <= '0;
		end else if (start) begin
			rx_data <= '0;
		end else if (state == ST_SHIFT && tick && sample_now) begin
			rx_data <= {rx_data[22:0], data_in};
		end
	end

	// Loopback entry detector
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			loopback_d <= 1'b0;
		end else begin
			loopback_d <= loopback;
		end
	end

	// Pin drivers: frozen during loopback, select latched on entry
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pins.sclk <= 1'b0;
			pins.mosi <= 1'b0;
			pins.ss_n <= 1'b1;
		end else if (loopback && !loopback_d) begin
			pins.ss_n <= ss_ctrl;
		end else if (!loopback) begin
			pins.sclk <= (state == ST_IDLE) ? serial_master_config.cpol : sclk_int;
			pins.mosi <= mosi_int;
			pins.ss_n <= ss_ctrl;
		end else begin
			pins <= pins;
		end
	end

	// Outputs to the pins and the host
	assign o_pins = pins;
	assign o_pins_enable = master_en;
	assign o_busy = (state != ST_IDLE);

	// Register read port, data one cycle after the request
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
			o_reg_rd_valid <= 1'b0;
		end else begin
			o_reg_rd_valid <= i_reg_rd_en;
			if (i_reg_rd_en) begin
				case (i_reg_addr)
					smlb_pkg::ADDR_PIN_CONFIG_ONE: begin
						o_reg_rdata <= pin_config_one;
					end
					smlb_pkg::ADDR_SERIAL_MASTER_CONFIG: begin
						o_reg_rdata <= {1'b0, serial_master_config};
					end
					smlb_pkg::ADDR_TRANSMIT_BYTE_LOW: begin
						o_reg_rdata <= transmit_byte_low;
					end
					smlb_pkg::ADDR_TRANSMIT_BYTE_MID: begin
						o_reg_rdata <= transmit_byte_mid;
					end
					smlb_pkg::ADDR_TRANSMIT_BYTE_HIGH: begin
						o_reg_rdata <= transmit_byte_high;
					end
					smlb_pkg::ADDR_TRANSFER_EXECUTE: begin
						o_reg_rdata <= transfer_execute;
					end
					smlb_pkg::ADDR_RECEIVE_BYTE_LOW: begin
						o_reg_rdata <= rx_data[7:0];
					end
					smlb_pkg::ADDR_RECEIVE_BYTE_MID: begin
						o_reg_rdata <= rx_data[15:8];
					end
					smlb_pkg::ADDR_RECEIVE_BYTE_HIGH: begin
						o_reg_rdata <= rx_data[23:16];
					end
					smlb_pkg::ADDR_COMM_DIAGNOSTIC_CONTROL: begin
						o_reg_rdata <= comm_diagnostic_control;
					end
					smlb_pkg::ADDR_TRANSFER_STATUS: begin
						o_reg_rdata <= {6'h00, done_flag, o_busy};
					end
					default: begin
						o_reg_rdata <= 8'h00;
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

/* design/smlb_pkg.sv */
// Package: register map, field layout, reset values and timing of the serial master
package smlb_pkg;

	// Register indices on the command port
	localparam logic [3:0] ADDR_PIN_CONFIG_ONE = 4'h0;
	localparam logic [3:0] ADDR_SERIAL_MASTER_CONFIG = 4'h1;
	localparam logic [3:0] ADDR_TRANSMIT_BYTE_LOW = 4'h2;
	localparam logic [3:0] ADDR_TRANSMIT_BYTE_MID = 4'h3;
	localparam logic [3:0] ADDR_TRANSMIT_BYTE_HIGH = 4'h4;
	localparam logic [3:0] ADDR_TRANSFER_EXECUTE = 4'h5;
	localparam logic [3:0] ADDR_RECEIVE_BYTE_LOW = 4'h6;
	localparam logic [3:0] ADDR_RECEIVE_BYTE_MID = 4'h7;
	localparam logic [3:0] ADDR_RECEIVE_BYTE_HIGH = 4'h8;
	localparam logic [3:0] ADDR_COMM_DIAGNOSTIC_CONTROL = 4'h9;
	localparam logic [3:0] ADDR_TRANSFER_STATUS = 4'hA;

	// Field positions
	localparam int MASTER_EN_BIT = 0;
	localparam int BIT_COUNT_LSB = 0;
	localparam int CPOL_BIT = 5;
	localparam int CPHA_BIT = 6;
	localparam int GO_BIT = 0;
	localparam int SS_CTRL_BIT = 1;
	localparam int LOOPBACK_BIT = 0;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;

	// Reset values
	localparam logic [7:0] RST_PIN_CONFIG_ONE = 8'h00;
	localparam logic [7:0] RST_SERIAL_MASTER_CONFIG = 8'h00;
	localparam logic [7:0] RST_TRANSMIT_BYTE = 8'h00;
	localparam logic [7:0] RST_TRANSFER_EXECUTE = 8'h02;
	localparam logic [7:0] RST_COMM_DIAGNOSTIC_CONTROL = 8'h00;

	// Transfer length limits
	localparam logic [4:0] BITS_MIN = 5'h01;
	localparam logic [4:0] BITS_MAX = 5'h18;
	localparam int DATA_WIDTH = 24;

	// Timing: serial clock period and derived half-period in system cycles
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int HALF_RAW = (SCLK_PERIOD_NS * 1000 / 2) / CLK_PERIOD_PS;
	localparam int HALF_CYCLES = (HALF_RAW < 1) ? 1 : HALF_RAW;
	localparam int HALF_CNT_W = 8;

	// Serial pin bundle
	typedef struct packed {
		logic sclk;
		logic mosi;
		logic ss_n;
	} smlb_pins_t;

	// Transfer configuration
	typedef struct packed {
		logic cpha;
		logic cpol;
		logic [4:0] bit_count;
	} smlb_cfg_t;

endpackage

/* design/smlb_sync.sv */
// Two-stage synchroniser for an input from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module smlb_sync (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_async,
	output logic o_sync
);

	logic meta;

	// First stage feeds only the second
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule
`default_nettype wire

/* test/smlb_master_props.sv */
// Port checker for the serial master
`timescale 1ns/10ps
`default_nettype none
module smlb_master_props (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_reg_wr_en,
	input wire logic i_reg_rd_en,
	input wire logic [3:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_reg_rd_valid,
	input wire logic i_miso,
	input wire smlb_pkg::smlb_pins_t o_pins,
	input wire logic o_pins_enable,
	input wire logic o_busy
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic lb, cpol, last_sclk;
	logic [4:0] nb;
	logic [5:0] edges;
	logic [3:0] quiet;
	wire logic wr_exe = i_reg_wr_en && i_reg_addr == 4'h5;
	// Shadow of loopback, polarity and length
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lb <= 1'b0;
			cpol <= 1'b0;
			nb <= 5'h01;
		end else if (i_reg_wr_en) begin
			if (i_reg_addr == 4'h9)
				lb <= i_reg_wdata[0];
			if (i_reg_addr == 4'h1) begin
				cpol <= i_reg_wdata[5];
				nb <= (i_reg_wdata[4:0] == 5'h00) ? 5'h01 :
					(i_reg_wdata[4:0] > 5'h18) ? 5'h18 : i_reg_wdata[4:0];
			end
		end
	end
	// Clock edges per transfer, idle cycles
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_sclk <= 1'b0;
			edges <= 6'h00;
			quiet <= 4'h0;
		end else begin
			last_sclk <= o_pins.sclk;
			edges <= !o_busy ? 6'h00 : edges + 6'(o_pins.sclk != last_sclk);
			quiet <= (o_busy || i_reg_wr_en) ? 4'h0 : (quiet == 4'hf) ? quiet : quiet + 4'h1;
		end
	end
	sequence s_go;
		wr_exe && i_reg_wdata == 8'h01 && !o_busy && o_pins_enable && !lb;
	endsequence
	sequence s_sel;
		o_busy ##1 !o_pins.ss_n;
	endsequence
	property p_rd_ans; i_reg_rd_en |=> o_reg_rd_valid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_en; i_reg_wr_en && i_reg_addr == 4'h0 |=> o_pins_enable == $past(i_reg_wdata[0]); endproperty
	a_en: assert property (p_en) else $error("pin mode wrong");
	property p_start; s_go |=> s_sel; endproperty
	a_start: assert property (p_start) else $error("start failed");
	property p_desel; wr_exe && i_reg_wdata == 8'h02 && !o_busy && !lb |=> ##1 o_pins.ss_n; endproperty
	a_desel: assert property (p_desel) else $error("deselect failed");
	property p_frozen; lb [*3] |-> $stable(o_pins); endproperty
	a_frozen: assert property (p_frozen) else $error("pins moved in loopback");
	property p_idle; quiet == 4'hf && !lb && o_pins_enable |-> o_pins.sclk == cpol; endproperty
	a_idle: assert property (p_idle) else $error("idle clock level wrong");
	property p_len; $fell(o_busy) && !lb |-> edges == {nb, 1'b0}; endproperty
	a_len: assert property (p_len) else $error("clock edge count wrong");
	property p_ss_busy; (o_busy && !lb) [*2] |-> !o_pins.ss_n; endproperty
	a_ss_busy: assert property (p_ss_busy) else $error("select high in transfer");
endmodule
bind smlb_master smlb_master_props u_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rd_valid(o_reg_rd_valid),
	.i_miso(i_miso), .o_pins(o_pins), .o_pins_enable(o_pins_enable), .o_busy(o_busy));
`default_nettype wire

/* test/smlb_slave.sv */
// Behavioural serial slave facing the master pins
`timescale 1ns/10ps
`default_nettype none
module smlb_slave (
	input wire smlb_pkg::smlb_pins_t i_pins,
	input wire logic i_cpol,
	input wire logic i_cpha,
	input wire logic [4:0] i_nbits,
	input wire logic [23:0] i_reply,
	input var int i_dly,
	output logic o_miso,
	output logic [23:0] o_got
);
	int k;
	initial o_miso = 1'b0;
	// Load on select, scramble line on release
	always @(i_pins.ss_n) begin
		if (!i_pins.ss_n) begin
			k = int'(i_nbits) - 1;
			o_got = 24'h00_0000;
			if (!i_cpha)
				put();
		end else
			o_miso <= #(i_dly) ~o_miso;
	end
	// Sample on the phase edge, shift out on the other
	always @(i_pins.sclk) begin
		if (!i_pins.ss_n) begin
			if ((i_pins.sclk != i_cpol) ^ i_cpha) begin
				o_got = {o_got[22:0], i_pins.mosi};
				if (i_cpha)
					k--;
			end else begin
				if (!i_cpha)
					k--;
				put();
			end
		end
	end
	task automatic put();
		o_miso <= #(i_dly) (k >= 0) ? i_reply[k] : ~o_miso;
	endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the serial master
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic i_clock, i_rst_n, wr, rd, rdv, en, busy, cpol, cpha;
	wire logic miso;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [4:0] nb;
	logic [23:0] rep;
	wire logic [23:0] got;
	smlb_pkg::smlb_pins_t pins, p0;
	int dly, error_cnt, checks, i;
	smlb_master DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_wr_en(wr), .i_reg_rd_en(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rd_valid(rdv),
		.i_miso(miso), .o_pins(pins), .o_pins_enable(en), .o_busy(busy));
	smlb_slave SLV (.i_pins(pins), .i_cpol(cpol), .i_cpha(cpha), .i_nbits(nb), .i_reply(rep),
		.i_dly(dly), .o_miso(miso), .o_got(got));
	// Clock
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	// Watchdog
	initial begin
		#500000;
		error_cnt++;
		stop_test();
	end
	task chk(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wreg(input logic [3:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge i_clock);
		wr = 1'b0;
		@(negedge i_clock);
	endtask
	task rreg(input logic [3:0] a, output logic [7:0] d);
		addr = a;
		rd = 1'b1;
		@(negedge i_clock);
		rd = 1'b0;
		chk(rdv, 1'b1);
		d = rdata;
		@(negedge i_clock);
	endtask
	function automatic logic [4:0] eff(input logic [4:0] n);
		return (n == 5'h00) ? 5'h01 : (n > 5'h18) ? 5'h18 : n;
	endfunction
	task xfer(input logic lb, input logic [7:0] cfg, input logic [23:0] tx);
		logic [7:0] b;
		logic [23:0] rx, m;
		int j;
		nb = eff(cfg[4:0]);
		cpol = cfg[5];
		cpha = cfg[6];
		m = (24'h00_0001 << nb) - 24'h00_0001;
		rep = 24'($urandom);
		dly = $urandom_range(30);
		wreg(4'h1, cfg);
		wreg(4'h2, tx[7:0]);
		wreg(4'h3, tx[15:8]);
		wreg(4'h4, tx[23:16]);
		wreg(4'h5, 8'h01);
		chk(pins.ss_n, lb);
		wreg(4'h5, 8'h02);
		chk(pins.ss_n, lb);
		for (j = 0; j < 1000; j++) begin
			rreg(4'hA, b);
			if (b[1] === 1'b1)
				break;
		end
		if (j == 1000) begin
			error_cnt++;
			stop_test();
		end
		chk(b[1:0], 2'b10);
		rreg(4'h6, rx[7:0]);
		rreg(4'h7, rx[15:8]);
		rreg(4'h8, rx[23:16]);
		chk(rx, (lb ? tx : rep) & m);
		if (!lb)
			chk(got & m, tx & m);
		wreg(4'h5, 8'h02);
		chk(pins.ss_n, 1'b1);
	endtask
	// Main sequence
	initial begin
		logic [7:0] b;
		{i_rst_n, wr, rd, addr, wdata, cpol, cpha, rep, dly, error_cnt, checks} = '0;
		nb = 5'h01;
		void'($urandom(67));
		repeat (4) @(negedge i_clock);
		i_rst_n = 1'b1;
		chk({pins, en, busy}, 5'b00100);
		for (i = 0; i < 12; i++)
			if (i < 6 || i > 8) begin
				rreg(i[3:0], b);
				chk(b, (i == 5) ? smlb_pkg::RST_TRANSFER_EXECUTE : 8'h00);
			end
		wreg(4'h5, 8'h01);
		repeat (3) @(negedge i_clock);
		chk({en, busy}, 2'b00);
		wreg(4'h5, 8'h02);
		wreg(4'h0, 8'h01);
		chk(en, 1'b1);
		$display("test reset and enable done");
		for (i = 0; i < 10; i++)
			xfer(1'b0, {1'b0, i[1:0], i[2] ? 5'h18 : (i[3] ? 5'h1f : 5'(i[0]))}, 24'($urandom));
		$display("test corners done");
		for (i = 0; i < 6; i++)
			xfer(1'b0, {1'b0, 2'($urandom), 5'($urandom_range(24, 1))}, 24'($urandom));
		$display("test random done");
		wreg(4'h9, 8'h01);
		p0 = pins;
		for (i = 0; i < 3; i++)
			xfer(1'b1, {1'b0, cpha, cpol, 5'($urandom_range(24, 1))}, 24'($urandom));
		chk(pins, p0);
		wreg(4'h9, 8'h00);
		$display("test loopback done");
		stop_test();
	end
endmodule
`default_nettype wire
